// ===== serial_timing_defs.svh
`ifndef SERIAL_TIMING_DEFS_SVH
`define SERIAL_TIMING_DEFS_SVH

// Master clock rate in kHz; the fractional dividers count in these units
`define REF_CLK_KHZ 17'd100000

// GCI bit clock rates in kHz, per operating mode
`define GCI_TE_KHZ 17'd1536
`define GCI_LT_KHZ 17'd4096
`define GCI_NT_KHZ 17'd512

// Auxiliary clock rates in kHz
`define AUX_LT_T_KHZ 17'd512
`define AUX_TE_KHZ 17'd768

// Last bit-clock period of an 8 kHz frame (192, 512 or 64 periods, less one);
// held as the last index because 512 itself does not fit the 9-bit counter
`define FRAME_KHZ 17'd8
`define FRAME_LAST_TE 9'd191
`define FRAME_LAST_LT 9'd511
`define FRAME_LAST_NT 9'd63

// PCM framing: 8-bit slots, port 1 in bit periods 0-7, port 2 in 8-15
`define PCM_SLOT_BITS 9'd8
`define PCM_PORT2_START 9'd8
`define PCM_PORT2_END 9'd16

// Link domain: 16.384 MHz reference, /4 for the clock, /2048 for the frame
`define LINK_REF_KHZ 17'd16384
`define LINK_CLK_KHZ 17'd4096
`define LINK_CNT_W 11
`define LINK_ALIGN_PHASE 11'h000

// Mode pin encodings
`define MODE_PINS_TE 2'h0
`define MODE_PINS_LT_T 2'h1
`define MODE_PINS_LT_S 2'h2
`define MODE_PINS_NT 2'h3

`endif

// ===== serial_timing_pkg.sv
package serial_timing_pkg;

   // Operating mode, decoded from the mode pins
   typedef enum logic [1:0] {
      MODE_TE,
      MODE_LT_T,
      MODE_LT_S,
      MODE_NT
   } op_mode_e;

   // Two PCM bytes to send in one frame
   typedef struct packed {
      logic [7:0] port1;
      logic [7:0] port2;
   } pcm_tx_s;

   // One PCM byte received from the codec
   typedef struct packed {
      logic valid;
      logic port2;
      logic [7:0] data;
   } pcm_rx_s;

endpackage

// ===== frac_div.sv
`timescale 1ns/1ps
`default_nettype none

// Fractional tick generator: mean tick rate is clk * step / modulus
module frac_div #(
   parameter int W = 17
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic run,
   input wire logic [W-1:0] step,
   input wire logic [W-1:0] modulus,
   // Tick
   output logic tick
);

   logic [W:0] sum;
   logic [W-1:0] acc_reg;

   // Wide sum so that the carry is never lost
   assign sum = {1'b0, acc_reg} + {1'b0, step};

   // Phase accumulator; cleared whenever stopped so restart phase is fixed
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_reg <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         acc_reg <= '0;
         tick <= 1'b0;
      end else if (sum >= {1'b0, modulus}) begin
         acc_reg <= W'(sum - {1'b0, modulus});
         tick <= 1'b1;
      end else begin
         acc_reg <= sum[W-1:0];
         tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ===== serial_bus_timing_gen.sv
// Functional notes
// - The GCI bit clock runs at twice the data rate, so each data bit spans two clock periods.
// - GCI bit clock is 1.536 MHz in terminal, 4.096 MHz in both line-termination, 512 kHz in network-termination mode.
// - A frame strobe at 8 kHz marks the start of every GCI frame.
// - The auxiliary clock output gives 512 kHz in line-termination-T and 768 kHz in terminal mode.
// - In line-termination modes an 8 kHz frame output is driven, edge-aligned to the 4.096 MHz PLL clock.
// - In line-termination modes the 4.096 MHz PLL clock stays locked to the recovered line timing.
// - The PLL clock and frame outputs are both derived from the 16.384 MHz reference input.
// - PCM port 1 strobe repeats at 8 kHz and is active for exactly eight PCM bit periods.
// - PCM port 2 strobe repeats at 8 kHz, eight bit periods wide, in its own slot.
// - The PCM bit clock is 1.536 MHz and shifts PCM data in and out.
// - The PCM transmit line carries at most two 64 kbit/s channels, one per framed slot.
// - The PCM receive line takes at most two 64 kbit/s channels, driven by the codec in the framed slots.
// - The PCM port works only in terminal mode and is idle in line-termination modes.
`timescale 1ns/1ps
`default_nettype none
`include "serial_timing_defs.svh"

module serial_bus_timing_gen (
   // Master clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Link reference clock for the PLL outputs
   input wire logic pll_reference_in,
   // Mode pins and recovered line frame pulse (ref_clk logic)
   input wire logic [1:0] mode_pins,
   input wire logic t_line_frame,
   // GCI timing
   output logic gci_bit_clock,
   output logic gci_frame_strobe,
   // Auxiliary clock
   output logic aux_clock_out,
   // PLL outputs
   output logic pll_clock_out,
   output logic pll_frame_out,
   // PCM port pins
   output logic pcm_bit_clock,
   output logic pcm_port1_strobe,
   output logic pcm_port2_strobe,
   output logic pcm_tx_line,
   output logic pcm_tx_line_oe,
   input wire logic pcm_rx_line,
   // PCM user side
   input wire serial_timing_pkg::pcm_tx_s pcm_tx_bytes,
   output serial_timing_pkg::pcm_rx_s pcm_rx_byte
);
   import serial_timing_pkg::*;

   // ****************************************
   // Mode pins
   // ****************************************

   logic [1:0] mode_s1_reg;
   logic [1:0] mode_s2_reg;
   op_mode_e mode;
   op_mode_e mode_prev_reg;
   logic run;

   // Pins come from outside, two flops before any use
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_s1_reg <= `MODE_PINS_TE;
         mode_s2_reg <= `MODE_PINS_TE;
      end else begin
         mode_s1_reg <= mode_pins;
         mode_s2_reg <= mode_s1_reg;
      end
   end

   // Decode of the synchronised mode pins
   always_comb begin
      if (mode_s2_reg == `MODE_PINS_LT_T) begin
         mode = MODE_LT_T;
      end else if (mode_s2_reg == `MODE_PINS_LT_S) begin
         mode = MODE_LT_S;
      end else if (mode_s2_reg == `MODE_PINS_NT) begin
         mode = MODE_NT;
      end else begin
         mode = MODE_TE;
      end
   end

   // A mode change parks both fractional dividers for one cycle, so they restart in phase
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_prev_reg <= MODE_TE;
      end else begin
         mode_prev_reg <= mode;
      end
   end

   assign run = (mode == mode_prev_reg);

   // ****************************************
   // GCI bit clock and frame strobe
   // ****************************************

   logic [16:0] gci_step;
   logic [8:0] frame_last;
   logic gci_tick;
   logic gci_rise;
   logic gci_fall;
   logic [8:0] bit_cnt_reg;
   logic [8:0] bit_cnt_next;

   // Toggle rate is twice the bit clock rate
   always_comb begin
      case (mode)
         MODE_LT_T, MODE_LT_S: begin
            gci_step = 17'(`GCI_LT_KHZ * 2);
            frame_last = `FRAME_LAST_LT;
         end
         MODE_NT: begin
            gci_step = 17'(`GCI_NT_KHZ * 2);
            frame_last = `FRAME_LAST_NT;
         end
         default: begin
            gci_step = 17'(`GCI_TE_KHZ * 2);
            frame_last = `FRAME_LAST_TE;
         end
      endcase
   end

   frac_div #(
      .W(17)
   ) gci_div (
      .clk(ref_clk),
      .resetn(resetn),
      .run(run),
      .step(gci_step),
      .modulus(`REF_CLK_KHZ),
      .tick(gci_tick)
   );

   assign gci_rise = gci_tick & ~gci_bit_clock;
   assign gci_fall = gci_tick & gci_bit_clock;
   assign bit_cnt_next = (bit_cnt_reg == frame_last) ? 9'h000 : bit_cnt_reg + 9'd1;

   // Bit clock; low after reset so the first edge is a rising one
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         gci_bit_clock <= 1'b0;
      end else if (!run) begin
         gci_bit_clock <= 1'b0;
      end else if (gci_tick) begin
         gci_bit_clock <= ~gci_bit_clock;
      end
   end

   // Clock periods in the frame; parked on the last period so the first rise is period 0
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt_reg <= `FRAME_LAST_TE;
      end else if (!run) begin
         bit_cnt_reg <= frame_last;
      end else if (gci_rise) begin
         bit_cnt_reg <= bit_cnt_next;
      end
   end

   // Frame strobe high for the whole first clock period of the frame
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         gci_frame_strobe <= 1'b0;
      end else if (!run) begin
         gci_frame_strobe <= 1'b0;
      end else if (gci_rise) begin
         gci_frame_strobe <= (bit_cnt_next == 9'h000);
      end
   end

   // ****************************************
   // Auxiliary clock
   // ****************************************

   logic aux_run;
   logic [16:0] aux_step;
   logic aux_tick;

   // Only terminal and line-termination-T modes use this pin
   assign aux_run = run & ((mode == MODE_TE) | (mode == MODE_LT_T));
   assign aux_step = (mode == MODE_LT_T) ? 17'(`AUX_LT_T_KHZ * 2) : 17'(`AUX_TE_KHZ * 2);

   frac_div #(
      .W(17)
   ) aux_div (
      .clk(ref_clk),
      .resetn(resetn),
      .run(aux_run),
      .step(aux_step),
      .modulus(`REF_CLK_KHZ),
      .tick(aux_tick)
   );

   // Held low in the modes without an auxiliary clock
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         aux_clock_out <= 1'b0;
      end else if (!aux_run) begin
         aux_clock_out <= 1'b0;
      end else if (aux_tick) begin
         aux_clock_out <= ~aux_clock_out;
      end
   end

   // ****************************************
   // PCM port (terminal mode only)
   // ****************************************

   logic pcm_on;
   logic [8:0] pcm_bit_next;
   logic in_slot_next;
   logic in_slot;
   pcm_tx_s tx_hold_reg;
   logic [7:0] rx_shift_reg;
   logic rx_s1_reg;
   logic rx_s2_reg;

   // Terminal bit clock equals the PCM rate, so the GCI divider is shared
   assign pcm_on = run & (mode == MODE_TE);
   assign pcm_bit_next = bit_cnt_next;
   assign in_slot_next = (pcm_bit_next < `PCM_PORT2_END);
   assign in_slot = (bit_cnt_reg < `PCM_PORT2_END);

   // PCM clock follows the bit clock, parked low outside terminal mode
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pcm_bit_clock <= 1'b0;
      end else if (!pcm_on) begin
         pcm_bit_clock <= 1'b0;
      end else if (gci_tick) begin
         pcm_bit_clock <= ~gci_bit_clock;
      end
   end

   // Strobes change on the rising edge that starts a bit period
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pcm_port1_strobe <= 1'b0;
         pcm_port2_strobe <= 1'b0;
      end else if (!pcm_on) begin
         pcm_port1_strobe <= 1'b0;
         pcm_port2_strobe <= 1'b0;
      end else if (gci_rise) begin
         pcm_port1_strobe <= (pcm_bit_next < `PCM_SLOT_BITS);
         pcm_port2_strobe <= (pcm_bit_next >= `PCM_PORT2_START) && in_slot_next;
      end
   end

   // Both bytes captured at frame start so a late update cannot tear a slot
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_hold_reg <= '0;
      end else if (gci_rise && (pcm_bit_next == 9'h000)) begin
         tx_hold_reg <= pcm_tx_bytes;
      end
   end

   // Transmit MSB first; line released outside the two slots for the pull-up
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pcm_tx_line <= 1'b1;
         pcm_tx_line_oe <= 1'b0;
      end else if (!pcm_on) begin
         pcm_tx_line <= 1'b1;
         pcm_tx_line_oe <= 1'b0;
      end else if (gci_rise) begin
         pcm_tx_line_oe <= in_slot_next;
         if (pcm_bit_next == 9'h000) begin
            pcm_tx_line <= pcm_tx_bytes.port1[7];
         end else if (pcm_bit_next < `PCM_PORT2_START) begin
            pcm_tx_line <= tx_hold_reg.port1[3'(7 - pcm_bit_next[2:0])];
         end else if (in_slot_next) begin
            pcm_tx_line <= tx_hold_reg.port2[3'(7 - pcm_bit_next[2:0])];
         end else begin
            pcm_tx_line <= 1'b1;
         end
      end
   end

   // Receive pin crosses in through two flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
      end else begin
         rx_s1_reg <= pcm_rx_line;
         rx_s2_reg <= rx_s1_reg;
      end
   end

   // Sampled mid-bit on the falling edge; eighth bit emits the byte
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_shift_reg <= 8'h00;
         pcm_rx_byte <= '0;
      end else begin
         pcm_rx_byte.valid <= 1'b0;
         if (pcm_on && gci_fall && in_slot) begin
            rx_shift_reg <= {rx_shift_reg[6:0], rx_s2_reg};
            if (bit_cnt_reg[2:0] == 3'h7) begin
               pcm_rx_byte.valid <= 1'b1;
               pcm_rx_byte.port2 <= bit_cnt_reg[3];
               pcm_rx_byte.data <= {rx_shift_reg[6:0], rx_s2_reg};
            end
         end
      end
   end

   // ****************************************
   // PLL outputs (link domain)
   // ****************************************

   logic lt_mode_reg;
   logic t_tog_reg;

   // Line-termination flag and line frame events leave the master domain
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lt_mode_reg <= 1'b0;
         t_tog_reg <= 1'b0;
      end else begin
         lt_mode_reg <= (mode == MODE_LT_T) || (mode == MODE_LT_S);
         t_tog_reg <= t_tog_reg ^ t_line_frame;
      end
   end

   logic link_rst_s1_reg;
   logic link_resetn;
   logic lt_s1_reg;
   logic lt_s2_reg;
   logic [2:0] t_sync_reg;
   logic [`LINK_CNT_W-1:0] link_cnt_reg;

   // Reset asserts at once and releases on a reference edge
   always_ff @(posedge pll_reference_in or negedge resetn) begin
      if (!resetn) begin
         link_rst_s1_reg <= 1'b0;
         link_resetn <= 1'b0;
      end else begin
         link_rst_s1_reg <= 1'b1;
         link_resetn <= link_rst_s1_reg;
      end
   end

   // Level and toggle synchronisers; third toggle flop gives the edge
   always_ff @(posedge pll_reference_in or negedge link_resetn) begin
      if (!link_resetn) begin
         lt_s1_reg <= 1'b0;
         lt_s2_reg <= 1'b0;
         t_sync_reg <= 3'h0;
      end else begin
         lt_s1_reg <= lt_mode_reg;
         lt_s2_reg <= lt_s1_reg;
         t_sync_reg <= {t_sync_reg[1:0], t_tog_reg};
      end
   end

   // Free count of reference cycles; a line frame snaps it back to phase 0
   always_ff @(posedge pll_reference_in or negedge link_resetn) begin
      if (!link_resetn) begin
         link_cnt_reg <= `LINK_ALIGN_PHASE;
      end else if (!lt_s2_reg || (t_sync_reg[2] ^ t_sync_reg[1])) begin
         link_cnt_reg <= `LINK_ALIGN_PHASE;
      end else begin
         link_cnt_reg <= link_cnt_reg + 11'd1;
      end
   end

   // Clock is count bit 1 (divide by four); frame spans one clock period
   always_ff @(posedge pll_reference_in or negedge link_resetn) begin
      if (!link_resetn) begin
         pll_clock_out <= 1'b0;
         pll_frame_out <= 1'b0;
      end else begin
         pll_clock_out <= lt_s2_reg & link_cnt_reg[1];
         pll_frame_out <= lt_s2_reg & (link_cnt_reg[`LINK_CNT_W-1:2] == 9'h000);
      end
   end

endmodule

`default_nettype wire

// ===== serial_bus_timing_gen_properties.sv
`timescale 1ns/1ps
`default_nettype none
module serial_bus_timing_gen_properties (
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic pll_reference_in,
   // Mode pins
   input wire logic [1:0] mode_pins,
   // Generated timing
   input wire logic gci_bit_clock,
   input wire logic gci_frame_strobe,
   input wire logic pll_clock_out,
   input wire logic pll_frame_out,
   // PCM port
   input wire logic pcm_bit_clock,
   input wire logic pcm_port1_strobe,
   input wire logic pcm_port2_strobe,
   input wire logic pcm_tx_line,
   input wire logic pcm_tx_line_oe,
   input wire serial_timing_pkg::pcm_rx_s pcm_rx_byte
);
   import serial_timing_pkg::*;
   // ****************************************
   // Assertions
   // ****************************************
   gci_strobe_rise_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) $rose(gci_frame_strobe) |-> $rose(gci_bit_clock))
      else $error("gci strobe rose off the bit clock rise");
   // A mode restart pulls the clock low, so only a live clock counts here
   gci_strobe_fall_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $fell(gci_frame_strobe) && gci_bit_clock |-> $rose(gci_bit_clock))
      else $error("gci strobe not one bit clock period");
   pcm_slot_edge_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) $rose(pcm_port1_strobe) |-> $rose(pcm_bit_clock))
      else $error("pcm slot one strobe off the bit clock rise");
   pcm_slots_apart_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) !(pcm_port1_strobe && pcm_port2_strobe))
      else $error("pcm slot strobes overlap");
   tx_drive_slot_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      pcm_port1_strobe || pcm_port2_strobe |-> pcm_tx_line_oe)
      else $error("pcm tx not driven in its slot");
   tx_idle_high_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) !pcm_tx_line_oe |-> pcm_tx_line)
      else $error("pcm tx not high while idle");
   rx_valid_pulse_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) pcm_rx_byte.valid |=> !pcm_rx_byte.valid)
      else $error("pcm rx valid longer than one cycle");
   pcm_idle_lt_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (mode_pins != 2'h0)[*6] |-> !pcm_bit_clock && !pcm_tx_line_oe)
      else $error("pcm port active outside terminal mode");
   pll_frame_width_a: assert property (
      @(posedge pll_reference_in) disable iff (!resetn)
      $rose(pll_frame_out) |-> pll_frame_out[*4] ##1 !pll_frame_out)
      else $error("pll frame pulse not four reference cycles");
   pll_clock_high_a: assert property (
      @(posedge pll_reference_in) disable iff (!resetn) $rose(pll_clock_out) |=> ##1 !pll_clock_out)
      else $error("pll clock high too long");
endmodule
`default_nettype wire

// ===== pcm_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_codec_model (
   // PCM pins
   input wire logic pcm_bit_clock,
   input wire logic pcm_port1_strobe,
   input wire logic pcm_port2_strobe,
   input wire logic pcm_tx_line,
   output logic pcm_rx_line,
   // Slot contents, port 1 in the upper byte
   input wire logic [15:0] send_bytes,
   output logic [15:0] got_bytes
);
   logic [3:0] bit_idx;
   initial begin
      pcm_rx_line = 1'b1;
      bit_idx = 4'h0;
      got_bytes = 16'h0000;
   end
   // Strobes move on the same edge as the clock, so look just after it
   always @(posedge pcm_bit_clock) begin
      #1;
      if (pcm_port1_strobe || pcm_port2_strobe) begin
         pcm_rx_line = send_bytes[4'hf - bit_idx];
         bit_idx = bit_idx + 4'h1;
      end else begin
         // Released line floats up to the pull-up
         pcm_rx_line = 1'b1;
         bit_idx = 4'h0;
      end
   end
   // Device launches on the rise, codec takes it on the fall
   always @(negedge pcm_bit_clock) begin
      if (pcm_port1_strobe || pcm_port2_strobe) begin
         got_bytes = {got_bytes[14:0], pcm_tx_line};
      end
   end
endmodule
`default_nettype wire

// ===== serial_bus_timing_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_bus_timing_gen_tb_top;
   import serial_timing_pkg::*;
   logic ref_clk = 1'b0;
   logic pll_reference_in = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] mode_pins = 2'h0;
   logic t_line_frame = 1'b0;
   pcm_tx_s pcm_tx_bytes = 16'h0000;
   pcm_rx_s pcm_rx_byte;
   logic pcm_rx_line, gci_bit_clock, gci_frame_strobe, aux_clock_out, pll_clock_out;
   logic pll_frame_out, pcm_bit_clock, pcm_port1_strobe, pcm_port2_strobe;
   logic pcm_tx_line, pcm_tx_line_oe;
   logic [15:0] got_bytes;
   int err_count = 0;
   int total_checks = 0;

   // Link clock free of any phase tie to the master clock
   always #5 ref_clk = ~ref_clk;
   initial #3.3 forever #7.5 pll_reference_in = ~pll_reference_in;

   serial_bus_timing_gen dut (.ref_clk, .resetn, .pll_reference_in, .mode_pins, .t_line_frame,
      .gci_bit_clock, .gci_frame_strobe, .aux_clock_out, .pll_clock_out, .pll_frame_out,
      .pcm_bit_clock, .pcm_port1_strobe, .pcm_port2_strobe, .pcm_tx_line, .pcm_tx_line_oe,
      .pcm_rx_line, .pcm_tx_bytes, .pcm_rx_byte);
   pcm_codec_model codec (.pcm_bit_clock, .pcm_port1_strobe, .pcm_port2_strobe, .pcm_tx_line,
      .pcm_rx_line, .send_bytes(16'hc35a), .got_bytes);

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic cyc;
      @(posedge ref_clk);
      #1;
   endtask
   // Range compare; an unknown never lands inside the range
   task automatic check(input string what, input int lo, input int hi, input logic [31:0] got);
      total_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         err_count++;
         $display("[FAIL] %s expected %0d..%0d seen %0h", what, lo, hi, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // One full frame per mode: period and edge counts of the GCI, aux and PCM clocks
   task automatic t_mode(input logic [1:0] m, input int bits, input int aux, input int pcm);
      int n, g, a, p, w;
      logic gp, ap, pp, sp, pl;
      mode_pins = m;
      w = 0;
      do begin
         sp = gci_frame_strobe;
         cyc();
         w++;
      end while (!(gci_frame_strobe && !sp) && w < 20000);
      n = 0;
      g = 0;
      a = 0;
      p = 0;
      pl = 1'b0;
      do begin
         sp = gci_frame_strobe;
         gp = gci_bit_clock;
         ap = aux_clock_out;
         pp = pcm_bit_clock;
         cyc();
         n++;
         g += (gci_bit_clock && !gp);
         a += (aux_clock_out && !ap);
         p += (pcm_bit_clock && !pp);
         pl = pl | pll_clock_out | pll_frame_out;
      end while (!(gci_frame_strobe && !sp) && n < 20000);
      check("frame period", 12499, 12501, n);
      check("gci clock edges", bits, bits, g);
      check("aux clock edges", aux, aux, a);
      check("pcm clock edges", pcm, pcm, p);
      if (m == 2'h0 || m == 2'h3) check("pll idle", 0, 0, pl);
   endtask

   // Link outputs: snap to the line frame, then period and clock count
   task automatic t_pll;
      int n, k;
      mode_pins = 2'h1;
      repeat (20) cyc();
      t_line_frame = 1'b1;
      cyc();
      t_line_frame = 1'b0;
      n = 0;
      while (!pll_frame_out && n < 40) begin
         cyc();
         n++;
      end
      check("pll snap delay", 0, 30, n);
      @(posedge pll_frame_out);
      n = 0;
      k = 0;
      fork
         @(posedge pll_frame_out);
         forever @(posedge pll_reference_in) n++;
         forever @(posedge pll_clock_out) k++;
      join_any
      disable fork;
      check("pll frame period", 2048, 2048, n);
      check("pll clock edges", 512, 512, k);
   endtask

   // Both PCM slots: strobe widths, transmit bytes and received bytes
   task automatic t_pcm;
      int n1, n2, w;
      logic sp;
      pcm_rx_s r1, r2;
      pcm_tx_bytes = 16'ha53c;
      w = 0;
      do begin
         sp = pcm_port1_strobe;
         cyc();
         w++;
      end while (!(pcm_port1_strobe && !sp) && w < 20000);
      n1 = 1;
      n2 = 0;
      w = 0;
      r1 = 10'h000;
      r2 = 10'h000;
      repeat (1300) begin
         cyc();
         n1 += pcm_port1_strobe;
         n2 += pcm_port2_strobe;
         if (pcm_rx_byte.valid === 1'b1) begin
            if (w == 0) r1 = pcm_rx_byte;
            else r2 = pcm_rx_byte;
            w++;
         end
      end
      check("port1 strobe width", 520, 521, n1);
      check("port2 strobe width", 520, 521, n2);
      check("rx byte count", 2, 2, w);
      check("rx slot one", 10'h2c3, 10'h2c3, r1);
      check("rx slot two", 10'h35a, 10'h35a, r2);
      check("tx both slots", 16'ha53c, 16'ha53c, got_bytes);
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      cyc();
      resetn = 1'b1;
      t_pll();
      t_mode(2'h0, 192, 96, 192);
      t_mode(2'h1, 512, 64, 0);
      t_mode(2'h2, 512, 0, 0);
      t_mode(2'h3, 64, 0, 0);
      t_mode(2'h0, 192, 96, 192);
      t_pcm();
      stop_test();
   end
   // Whole run is near 83k cycles; 100k cycles means a hang
   initial begin
      #1000000;
      err_count++;
      stop_test();
   end
endmodule
bind serial_bus_timing_gen serial_bus_timing_gen_properties checker_i (.ref_clk, .resetn,
   .pll_reference_in, .mode_pins, .gci_bit_clock, .gci_frame_strobe, .pll_clock_out,
   .pll_frame_out, .pcm_bit_clock, .pcm_port1_strobe, .pcm_port2_strobe, .pcm_tx_line,
   .pcm_tx_line_oe, .pcm_rx_byte);
`default_nettype wire
